// *** hdl/status_query_regs.svh ***
// Field positions, select codes and reset values of the status query block
`ifndef STATUS_QUERY_REGS_SVH
`define STATUS_QUERY_REGS_SVH

// ----------------------------------------------------------------
// Select codes
// ----------------------------------------------------------------
`define SEL_BUS_ROLE 4'h0
`define SEL_INT_STAT1 4'h1
`define SEL_INT_STAT2 4'h2
`define SEL_DMA_STAT 4'h3
`define SEL_OUT_TERM0 4'h4
`define SEL_OUT_TERM1 4'h5
`define SEL_OUT_TERM2 4'h6
`define SEL_OUT_TERM3 4'h7
`define SEL_IN_TERM0 4'h8
`define SEL_IO_TIMEOUT 4'h9
`define SEL_DMA_TIMEOUT 4'hA
`define SEL_IN_TERM1 4'hB
`define SEL_IN_TERM2 4'hC
`define SEL_IN_TERM3 4'hD
`define SEL_PORT_ADDR 4'hE
`define SEL_BUS_ADDR 4'hF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ROLE_CTRL_BIT 7
`define ROLE_LISTEN_BIT 2
`define ROLE_TALK_BIT 1
`define TERM_LEN_BIT 1
`define TERM_EOI_BIT 0
`define SEL_CODE_WIDTH 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEL_RESET 8'h00
`define WORD_RESET 16'h0000

`endif

// *** hdl/status_query_pkg.sv ***
// Types shared by the status query block
package status_query_pkg;
   typedef logic [3:0] param_select_t;
   typedef logic [15:0] param_word_t;
   typedef logic [7:0] query_byte_t;
   typedef enum logic [1:0] {ST_IDLE, ST_DONE} query_state_t;
endpackage : status_query_pkg

// *** hdl/bus_role_status.sv ***
// Bus role status register: controller, listener and talker flags
`timescale 1ns/1ns
`include "status_query_regs.svh"
module bus_role_status (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic controller_role,
   input wire logic listener_addressed,
   input wire logic talker_addressed,
   output logic [7:0] bus_role_status_reg
);
   import status_query_pkg::*;

   // Role flags sit in their own bits; undefined bits stay zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bus_role_status_reg <= 8'h00;
      end else begin
         bus_role_status_reg <= 8'h00;
         bus_role_status_reg[`ROLE_CTRL_BIT] <= controller_role;
         bus_role_status_reg[`ROLE_LISTEN_BIT] <= listener_addressed;
         bus_role_status_reg[`ROLE_TALK_BIT] <= talker_addressed;
      end
   end

   // The register lags its inputs by one edge, so no check until reset was high an edge ago
   a_ctrl_flag_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> bus_role_status_reg[7] == $past(controller_role))
      else $error("controller flag does not follow role");
   a_listen_flag_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> bus_role_status_reg[2] == $past(listener_addressed))
      else $error("listener flag does not follow addressing");
   a_talk_flag_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> bus_role_status_reg[1] == $past(talker_addressed))
      else $error("talker flag does not follow addressing");
   a_undef_bits_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_role_status_reg & 8'h79) == 8'h00)
      else $error("undefined role bits not zero");
endmodule : bus_role_status

// *** hdl/status_parameter_query.sv ***
// Status and setup parameter readback for the bus interface board
`timescale 1ns/1ns
`include "status_query_regs.svh"

module status_parameter_query (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic query_valid,
   input wire status_query_pkg::query_byte_t query_sel,
   output status_query_pkg::query_byte_t sel_return,
   output status_query_pkg::param_word_t stat_return,
   output logic query_done,
   input wire logic controller_role,
   input wire logic listener_addressed,
   input wire logic talker_addressed,
   input wire status_query_pkg::query_byte_t int_status1,
   input wire status_query_pkg::query_byte_t int_status2,
   input wire status_query_pkg::query_byte_t dma_status,
   input wire status_query_pkg::param_word_t out_term0,
   input wire status_query_pkg::param_word_t out_term1,
   input wire status_query_pkg::param_word_t out_term2,
   input wire status_query_pkg::param_word_t out_term3,
   input wire logic [3:0] out_term_two_byte,
   input wire logic [3:0] out_term_eoi,
   input wire status_query_pkg::query_byte_t in_term0,
   input wire status_query_pkg::query_byte_t in_term1,
   input wire status_query_pkg::query_byte_t in_term2,
   input wire status_query_pkg::query_byte_t in_term3,
   input wire status_query_pkg::param_word_t io_timeout,
   input wire status_query_pkg::param_word_t dma_timeout,
   input wire status_query_pkg::param_word_t port_address,
   input wire status_query_pkg::query_byte_t bus_address,
   input wire logic term_send_last,
   input wire logic [1:0] term_send_index,
   output logic term_eoi_out
);
   import status_query_pkg::*;

   // ----------------------------------------------------------------
   // Role status register
   // ----------------------------------------------------------------
   logic [7:0] role_reg;
   bus_role_status u_bus_role_status (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .controller_role(controller_role),
      .listener_addressed(listener_addressed),
      .talker_addressed(talker_addressed),
      .bus_role_status_reg(role_reg)
   );

   // ----------------------------------------------------------------
   // Select decoding
   // ----------------------------------------------------------------
   // True for the four output terminator codes; used by the selector path only
   function automatic logic is_out_term(input param_select_t code);
      is_out_term = (code >= `SEL_OUT_TERM0) && (code <= `SEL_OUT_TERM3);
   endfunction : is_out_term

   param_select_t code;
   assign code = query_sel[`SEL_CODE_WIDTH-1:0];

   param_word_t stat_next;
   query_byte_t sel_next;

   // Item mux; byte-wide items are zero-extended so the upper byte reads zero
   always_comb begin
      stat_next = `WORD_RESET;
      if (code == `SEL_BUS_ROLE) begin
         stat_next = {8'h00, role_reg};
      end else if (code == `SEL_INT_STAT1) begin
         stat_next = {8'h00, int_status1};
      end else if (code == `SEL_INT_STAT2) begin
         stat_next = {8'h00, int_status2};
      end else if (code == `SEL_DMA_STAT) begin
         stat_next = {8'h00, dma_status};
      end else if (code == `SEL_OUT_TERM0) begin
         stat_next = out_term0;
      end else if (code == `SEL_OUT_TERM1) begin
         stat_next = out_term1;
      end else if (code == `SEL_OUT_TERM2) begin
         stat_next = out_term2;
      end else if (code == `SEL_OUT_TERM3) begin
         stat_next = out_term3;
      end else if (code == `SEL_IN_TERM0) begin
         stat_next = {8'h00, in_term0};
      end else if (code == `SEL_IO_TIMEOUT) begin
         stat_next = io_timeout;
      end else if (code == `SEL_DMA_TIMEOUT) begin
         stat_next = dma_timeout;
      end else if (code == `SEL_IN_TERM1) begin
         stat_next = {8'h00, in_term1};
      end else if (code == `SEL_IN_TERM2) begin
         stat_next = {8'h00, in_term2};
      end else if (code == `SEL_IN_TERM3) begin
         stat_next = {8'h00, in_term3};
      end else if (code == `SEL_PORT_ADDR) begin
         stat_next = port_address;
      end else begin
         stat_next = {8'h00, bus_address};
      end
   end

   // Selector return: flags for output terminators, else echo the input
   always_comb begin
      sel_next = query_sel;
      if (is_out_term(code)) begin
         sel_next = 8'h00;
         sel_next[`TERM_LEN_BIT] = out_term_two_byte[code[1:0]];
         sel_next[`TERM_EOI_BIT] = out_term_eoi[code[1:0]];
      end
   end

   // ----------------------------------------------------------------
   // Answer registers
   // ----------------------------------------------------------------
   // Answer is captured one cycle after the request and held until the next
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sel_return <= `SEL_RESET;
         stat_return <= `WORD_RESET;
      end else if (query_valid) begin
         sel_return <= sel_next;
         stat_return <= stat_next;
      end
   end

   // Done strobe one cycle after the request
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         query_done <= 1'b0;
      end else begin
         query_done <= query_valid;
      end
   end

   // ----------------------------------------------------------------
   // EOI with the final terminator byte
   // ----------------------------------------------------------------
   // Registered so EOI lines up with the byte the sender presents next cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         term_eoi_out <= 1'b0;
      end else begin
         term_eoi_out <= term_send_last && out_term_eoi[term_send_index];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Strobe shape and answer hold; the release edge itself still resets, so skip it
   a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid |=> query_done)
      else $error("done missing after request");
   a_done_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && !query_valid |=> !query_done)
      else $error("done raised without a request");
   a_answer_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && !query_valid |=> $stable(sel_return) && $stable(stat_return))
      else $error("answer changed without a request");
   // Selector return for each code group
   a_sel_echo: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:2] != 2'b01 |=> sel_return == $past(query_sel))
      else $error("selector not echoed");
   a_out_term_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:2] == 2'b01 |=> sel_return[7:2] == 6'h00 &&
      sel_return[1] == $past(out_term_two_byte[query_sel[1:0]]))
      else $error("terminator flags wrong");
   a_out_term_eoi_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:2] == 2'b01 |=>
      sel_return[0] == $past(out_term_eoi[query_sel[1:0]]))
      else $error("terminator end flag wrong");
   // Returned word per code; upper selector bits are random in the bench
   a_upper_bits_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:0] == 4'h0 |=> stat_return == {8'h00, $past(role_reg)})
      else $error("role status not returned for code 0");
   a_out_term_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:0] == 4'h4 |=> stat_return == $past(out_term0))
      else $error("output terminator 0 not on code 4");
   a_timeout_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:0] == 4'h9 |=> stat_return == $past(io_timeout))
      else $error("io timeout not on code 9");
   a_dma_timeout_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:0] == 4'hA |=> stat_return == $past(dma_timeout))
      else $error("dma timeout not on code 10");
   a_in_term_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:0] == 4'hB |=> stat_return == {8'h00, $past(in_term1)})
      else $error("input terminator upper byte not zero");
   a_port_addr_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:0] == 4'hE |=> stat_return == $past(port_address))
      else $error("port address not on code 14");
   a_bus_addr_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && query_sel[3:0] == 4'hF |=> stat_return == {8'h00, $past(bus_address)})
      else $error("bus address not on code 15");
   a_byte_items_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && query_valid && (query_sel[3:2] == 2'b00 || query_sel[3:0] == 4'h8 ||
      (query_sel[3:0] >= 4'hB && query_sel[3:0] <= 4'hD) || query_sel[3:0] == 4'hF) |=>
      stat_return[15:8] == 8'h00)
      else $error("byte item upper byte not zero");
   // EOI follows the last-byte strobe and the chosen terminator's end flag
   a_eoi_last_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && !term_send_last |=> !term_eoi_out)
      else $error("EOI outside last terminator byte");
   a_eoi_with_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && term_send_last && out_term_eoi[term_send_index] |=> term_eoi_out)
      else $error("EOI missing on last terminator byte");
   a_eoi_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && !out_term_eoi[term_send_index] |=> !term_eoi_out)
      else $error("EOI raised with end flag clear");
endmodule : status_parameter_query

// *** tb/status_parameter_query_tb.sv ***
// Self-checking bench for the status and parameter query block
`timescale 1ns/1ns
module status_parameter_query_tb;
   import status_query_pkg::*;
   logic clk_sys, rst_n, query_valid, query_done, term_eoi_out, term_send_last;
   logic controller_role, listener_addressed, talker_addressed;
   query_byte_t query_sel, sel_return, int_status1, int_status2, dma_status, bus_address;
   query_byte_t in_term0, in_term1, in_term2, in_term3;
   param_word_t stat_return, out_term0, out_term1, out_term2, out_term3;
   param_word_t io_timeout, dma_timeout, port_address;
   logic [3:0] out_term_two_byte, out_term_eoi;
   logic [1:0] term_send_index;
   int bad_count, n_compared, seed;

   // ------------------------------------------------
   // Checking helpers
   // ------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      n_compared++;
      if (seen !== expected) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expected);
      end
   endtask : check

   task automatic final_report();
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // Release reset at an edge; that edge still resets, so outputs read zero just after
   task automatic release_check();
      rst_n <= 1'b1;
      #1;
      check({sel_return, 7'h00, query_done}, 16'h0000);
      check(stat_return, 16'h0000);
      check(16'(term_eoi_out), 16'h0000);
   endtask : release_check

   function automatic logic [15:0] rw(input bit ones);
      return ones ? 16'hFFFF : 16'($random(seed));
   endfunction : rw

   // Word expected for a select code; byte items come back zero-extended
   function automatic param_word_t exp_stat(input param_select_t c);
      case (c)
         4'h0: return {8'h00, controller_role, 4'h0, listener_addressed, talker_addressed, 1'b0};
         4'h1: return {8'h00, int_status1};
         4'h2: return {8'h00, int_status2};
         4'h3: return {8'h00, dma_status};
         4'h4: return out_term0;
         4'h5: return out_term1;
         4'h6: return out_term2;
         4'h7: return out_term3;
         4'h8: return {8'h00, in_term0};
         4'h9: return io_timeout;
         4'hA: return dma_timeout;
         4'hB: return {8'h00, in_term1};
         4'hC: return {8'h00, in_term2};
         4'hD: return {8'h00, in_term3};
         4'hE: return port_address;
         default: return {8'h00, bus_address};
      endcase
   endfunction : exp_stat

   // Only output terminator codes rewrite the selector
   function automatic query_byte_t exp_sel(input query_byte_t s);
      if (s[3:2] == 2'b01) begin
         return {6'h00, out_term_two_byte[s[1:0]], out_term_eoi[s[1:0]]};
      end
      return s;
   endfunction : exp_sel

   // ------------------------------------------------
   // Stimulus
   // ------------------------------------------------
   // Sources change only between bursts so the lagging role register settles
   task automatic set_src(input bit ones);
      {controller_role, listener_addressed, talker_addressed} <= 3'(rw(ones));
      int_status1 <= 8'(rw(ones));
      int_status2 <= 8'(rw(ones));
      dma_status <= 8'(rw(ones));
      {out_term0, out_term1, out_term2, out_term3} <= {rw(ones), rw(ones), rw(ones), rw(ones)};
      {out_term_two_byte, out_term_eoi} <= 8'(rw(ones));
      {in_term0, in_term1, in_term2, in_term3} <= {rw(ones), rw(ones)};
      {io_timeout, dma_timeout, port_address} <= {rw(ones), rw(ones), rw(ones)};
      bus_address <= 8'(rw(ones));
   endtask : set_src

   // All sixteen codes back to back, each answer checked the cycle after
   task automatic burst(input bit ones);
      query_byte_t s, prev;
      logic pe;
      for (int i = 0; i <= 16; i++) begin
         @(posedge clk_sys);
         pe = term_send_last & out_term_eoi[term_send_index];
         s = {(ones ? 4'hF : 4'($random(seed))), 4'(i)};
         query_valid <= (i < 16);
         query_sel <= s;
         term_send_last <= 1'($random(seed));
         term_send_index <= 2'($random(seed));
         #1;
         check(16'(term_eoi_out), 16'(pe));
         if (i > 0) begin
            check(16'(query_done), 16'h0001);
            check(16'(sel_return), 16'(exp_sel(prev)));
            check(stat_return, exp_stat(prev[3:0]));
         end
         prev = s;
      end
      @(posedge clk_sys);
      #1;
      check(16'(query_done), 16'h0000);
   endtask : burst

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Watchdog: the run needs about eight hundred cycles
   initial begin
      #100000;
      bad_count++;
      final_report();
   end

   initial begin
      seed = 40;
      rst_n = 1'b0;
      query_valid = 1'b0;
      query_sel = 8'h00;
      term_send_last = 1'b0;
      term_send_index = 2'h0;
      set_src(1'b0);
      repeat (4) @(posedge clk_sys);
      release_check();
      // First burst is the all-ones corner case, then random, with a reset in mid-run
      for (int b = 0; b < 40; b++) begin
         if (b == 20) begin
            @(posedge clk_sys);
            rst_n <= 1'b0;
            repeat (2) @(posedge clk_sys);
            release_check();
         end
         @(posedge clk_sys);
         set_src(b == 0);
         @(posedge clk_sys);
         burst(b == 0);
      end
      final_report();
   end

   status_parameter_query u_status_parameter_query (
      .clk_sys(clk_sys), .rst_n(rst_n), .query_valid(query_valid), .query_sel(query_sel),
      .sel_return(sel_return), .stat_return(stat_return), .query_done(query_done),
      .controller_role(controller_role), .listener_addressed(listener_addressed),
      .talker_addressed(talker_addressed), .int_status1(int_status1),
      .int_status2(int_status2), .dma_status(dma_status), .out_term0(out_term0),
      .out_term1(out_term1), .out_term2(out_term2), .out_term3(out_term3),
      .out_term_two_byte(out_term_two_byte), .out_term_eoi(out_term_eoi),
      .in_term0(in_term0), .in_term1(in_term1), .in_term2(in_term2), .in_term3(in_term3),
      .io_timeout(io_timeout), .dma_timeout(dma_timeout), .port_address(port_address),
      .bus_address(bus_address), .term_send_last(term_send_last),
      .term_send_index(term_send_index), .term_eoi_out(term_eoi_out)
   );
endmodule : status_parameter_query_tb
